// File: hdl/mrc_defines.vh
/*
 Constants for the motor run command block: register offsets, field
 positions, reset values and timing counts.
 Assumes inclusion by bare name from the design files.
*/
`ifndef MRC_DEFINES_VH
`define MRC_DEFINES_VH

// Register byte offsets
`define MRC_ADDR_CTRL        8'h00
`define MRC_ADDR_STATUS      8'h04
`define MRC_ADDR_PENDING     8'h08
`define MRC_ADDR_SPEED_BASE  8'h10
`define MRC_ADDR_ACCEL_BASE  8'h20
`define MRC_ADDR_DECEL_BASE  8'h30

// Control fields
`define MRC_CTRL_MODE_LSB    0
`define MRC_CTRL_VIEW_LSB    2
`define MRC_CTRL_SETS_LSB    4

// External operation setting values
`define MRC_MODE_PANEL       2'h0
`define MRC_MODE_EXT_PANEL   2'h1
`define MRC_MODE_EXT_ONLY    2'h2

// Monitor views
`define MRC_VIEW_SPEED       2'h0
`define MRC_VIEW_ALARM       2'h1
`define MRC_VIEW_WARN        2'h2
`define MRC_VIEW_IO          2'h3

// Reset values and dial speed limit
`define MRC_SPEED_RST        16'h0000
`define MRC_ACCEL_RST        16'h0000
`define MRC_DECEL_RST        16'h0000
`define MRC_SPEED_MAX        16'hFFFF

// Display and alarm codes
`define MRC_LOCKOUT_CODE     8'h46

// Rotation pulse output
`define MRC_PULSES_PER_REV   8'd30
`define MRC_TICKS_PER_REV    8'd60

// Timing: disabled indication hold, 2 s at 100 MHz
`define MRC_CLK_HZ           100000000
`define MRC_IND_HOLD_MS      2000
`define MRC_IND_HOLD_CYC     ((`MRC_CLK_HZ / 1000) * `MRC_IND_HOLD_MS)

// Cycles after reset release before the run switch strap is caught
`define MRC_STARTUP_CYC      2'd3

`endif

// File: hdl/mrc_sync.v
/*
 Two-stage synchroniser for a group of pin inputs.
 Assumes asynchronous inputs and one clock; the first stage feeds only
 the second.
*/
module mrc_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk,   // System clock
   input  wire             srst,  // Synchronous reset, active high
   input  wire [WIDTH-1:0] din,   // Asynchronous inputs
   output wire [WIDTH-1:0] dout   // Synchronised outputs
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg stage1;
         reg stage2;
         always @(posedge clk) begin
            if (srst) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               stage1 <= din[i];
               stage2 <= stage1;
            end
         end
         assign dout[i] = stage2;
      end
   endgenerate

endmodule

// File: hdl/mrc_top.v
/*
 Run/stop, direction and speed command control for a brushless motor
 driver, with an AHB-Lite register slave.
 Assumes panel switches, external run inputs and motor feedback arrive
 asynchronously on pins; the power stage ramps per accel/decel times.
*/
// What this block does
// - Run switch at run during power-up shows lockout code and blocks running
// - Returning switch to run starts the motor at the set speed
// - Dialled speed stays pending until dial press stores it in set zero
// - Direction switch changes are accepted while running
// - External operation setting has three values: panel, external plus panel, external only
// - External-only ignores run switch, direction switch and dial speed changes
// - External-plus-panel runs only with run input and switch at run
// - External-plus-panel: dial alters speed, direction switch reverses rotation
// - External-only: disabled indication while switch at run, two seconds otherwise
// - External-only: dial in speed, alarm or warning view shows disabled
// - External control rotates motor when exactly one run input is active
// - Releasing the active run input decelerates the motor to standstill
// - Both run inputs active stops the motor instantly without ramp when one or two sets are in use
// - Two select inputs pick one of four data sets: speed, accel, decel
// - With three or more sets in use the reverse run input is ignored; only the direction switch can still reverse, in external-plus-panel
// - Changing select inputs while running moves to new speed without stopping
// - Direction change decelerates to standstill then restarts in new direction
// - External-only treats direction switch as forward position
// - Rotation pulse output gives thirty pulses per output shaft revolution
// - Fault output is active normally and inactive on any alarm
`include "mrc_defines.vh"

module mrc_top #(
   parameter [27:0] IND_HOLD_CYC = `MRC_IND_HOLD_CYC
) (
   input  wire        clk,                        // System clock 100 MHz
   input  wire        srst,                       // Synchronous reset, active high
   input  wire        hsel,                       // AHB select
   input  wire [7:0]  haddr,                      // AHB address
   input  wire [1:0]  htrans,                     // AHB transfer type
   input  wire        hwrite,                     // AHB write
   input  wire [2:0]  hsize,                      // AHB size
   input  wire [31:0] hwdata,                     // AHB write data
   input  wire        hready,                     // AHB bus ready
   output reg         hreadyout,                  // AHB slave ready
   output reg  [31:0] hrdata,                     // AHB read data
   output reg         hresp,                      // AHB response, always OKAY
   input  wire        runSwitch,                  // Operation switch, 1 = run
   input  wire        dirSwitch,                  // Direction switch, 1 = reverse side
   input  wire        dialUp,                     // Dial step up, level toggles per detent
   input  wire        dialDown,                   // Dial step down, level toggles per detent
   input  wire        dialPress,                  // Dial pressed, high while pressed
   input  wire        forward_run_input,          // External forward run
   input  wire        counter_direction_run_input, // External reverse run
   input  wire        speed_select_low_bit,       // Data set select bit 0
   input  wire        speed_select_high_bit,      // Data set select bit 1
   input  wire        motorStill,                 // Motor at standstill
   input  wire        motorTick,                  // Shaft position tick
   input  wire        alarmIn,                    // Power stage alarm
   output reg         runCmd,                     // Motor drive command
   output reg         dirCmd,                     // 0 = clockwise
   output reg         instantStop,                // Stop without ramp
   output reg  [15:0] speedCmd,                   // Commanded speed
   output reg  [15:0] accelCmd,                   // Commanded accel time
   output reg  [15:0] decelCmd,                   // Commanded decel time
   output reg  [1:0]  activeSet,                  // Data set in use
   output reg  [7:0]  power_on_run_lockout_code,  // Alarm code shown, 0 when none
   output reg         disabledInd,                // Disabled indication shown
   output reg         pendingBlink,               // Speed display blinking
   output reg         rotPulse,                   // Rotation pulse output
   output reg         fault_output                // High normal, low on alarm
);

   ////////////////////////////////////////////////////////////////////
   // Input synchronisers

   wire [12:1] pinS;
   mrc_sync #(.WIDTH(12)) u_sync (
      .clk  (clk),
      .srst (srst),
      .din  ({runSwitch, dirSwitch, dialUp, dialDown, dialPress,
              forward_run_input, counter_direction_run_input,
              speed_select_low_bit, speed_select_high_bit,
              motorStill, motorTick, alarmIn}),
      .dout (pinS)
   );

   wire runSw   = pinS[12];
   wire dirSw   = pinS[11];
   wire upS     = pinS[10];
   wire downS   = pinS[9];
   wire pressS  = pinS[8];
   wire fwdS    = pinS[7];
   wire revS    = pinS[6];
   wire selLoS  = pinS[5];
   wire selHiS  = pinS[4];
   wire stillS  = pinS[3];
   wire tickS   = pinS[2];
   wire alarmS  = pinS[1];

   reg  [5:1] prevPin;
   wire       upEv    = upS ^ prevPin[5];
   wire       downEv  = downS ^ prevPin[4];
   wire       pressEv = pressS & ~prevPin[3];
   wire       dirEv   = dirSw ^ prevPin[2];
   wire       tickEv  = tickS & ~prevPin[1];

   function oneRun;
      input f;
      input r;
      begin
         oneRun = f ^ r;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Register file and AHB-Lite slave

   reg  [1:0]  extMode;
   reg  [1:0]  monView;
   reg  [1:0]  setsUsed;       // Sets in use minus one
   reg  [15:0] pendSpeed;
   reg  [15:0] speedTab [0:3];
   reg  [15:0] accelTab [0:3];
   reg  [15:0] decelTab [0:3];
   reg         wrPend;
   reg  [7:0]  wrAddr;
   reg         lockout;
   reg         instStopped;
   reg  [4:0]  state;
   integer     k;

   wire addrPhase = hsel & hready & htrans[1];
   wire [31:0] statusWord = {16'h0000, 4'h0, fault_output, instStopped, pendingBlink,
                             disabledInd, lockout, activeSet, state[4:0]};

   always @(posedge clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
         wrPend    <= 1'b0;
         wrAddr    <= 8'h00;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend    <= addrPhase & hwrite;
         wrAddr    <= haddr;
         if (addrPhase & ~hwrite) begin
            case (haddr & 8'hF0)
               8'h00: begin
                  case (haddr)
                     `MRC_ADDR_CTRL:   hrdata <= {26'h0, setsUsed, monView, extMode};
                     `MRC_ADDR_STATUS: hrdata <= statusWord;
                     `MRC_ADDR_PENDING: hrdata <= {16'h0000, pendSpeed};
                     default:          hrdata <= 32'h00000000;
                  endcase
               end
               `MRC_ADDR_SPEED_BASE: hrdata <= {16'h0000, speedTab[haddr[3:2]]};
               `MRC_ADDR_ACCEL_BASE: hrdata <= {16'h0000, accelTab[haddr[3:2]]};
               `MRC_ADDR_DECEL_BASE: hrdata <= {16'h0000, decelTab[haddr[3:2]]};
               default:              hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   wire bankWr = wrPend & (wrAddr[1:0] == 2'h0);

   always @(posedge clk) begin
      if (srst) begin
         extMode   <= `MRC_MODE_PANEL;
         monView   <= `MRC_VIEW_SPEED;
         setsUsed  <= 2'h0;
         pendSpeed <= `MRC_SPEED_RST;
         for (k = 0; k < 4; k = k + 1) begin
            speedTab[k] <= `MRC_SPEED_RST;
            accelTab[k] <= `MRC_ACCEL_RST;
            decelTab[k] <= `MRC_DECEL_RST;
         end
      end else begin
         if (bankWr && wrAddr == `MRC_ADDR_CTRL) begin
            if (hwdata[1:0] != 2'h3)
               extMode <= hwdata[1:0];
            monView  <= hwdata[3:2];
            setsUsed <= hwdata[5:4];
         end
         if (bankWr && (wrAddr & 8'hF0) == `MRC_ADDR_SPEED_BASE)
            speedTab[wrAddr[3:2]] <= hwdata[15:0];
         if (bankWr && (wrAddr & 8'hF0) == `MRC_ADDR_ACCEL_BASE)
            accelTab[wrAddr[3:2]] <= hwdata[15:0];
         if (bankWr && (wrAddr & 8'hF0) == `MRC_ADDR_DECEL_BASE)
            decelTab[wrAddr[3:2]] <= hwdata[15:0];
         // Dial acts on speed only outside external-only setting
         if (extMode != `MRC_MODE_EXT_ONLY) begin
            if (upEv && pendSpeed != `MRC_SPEED_MAX)
               pendSpeed <= pendSpeed + 16'h0001;
            else if (downEv && pendSpeed != 16'h0000)
               pendSpeed <= pendSpeed - 16'h0001;
            if (pressEv)
               speedTab[0] <= pendSpeed;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Run demand resolution

   reg        runWanted;
   reg        wantDir;
   reg        bothRun;
   reg  [1:0] setIdx;
   reg        revUse;

   always @* begin
      // Three or more sets: reverse input unused, run inputs give one direction only
      revUse    = revS & (setsUsed < 2'h2);
      bothRun   = 1'b0;
      runWanted = 1'b0;
      wantDir   = 1'b0;
      setIdx    = 2'h0;
      case (extMode)
         `MRC_MODE_EXT_PANEL: begin
            bothRun   = fwdS & revUse;
            runWanted = runSw & oneRun(fwdS, revUse);
            wantDir   = dirSw ^ revUse;
            setIdx    = {selHiS, selLoS};
         end
         `MRC_MODE_EXT_ONLY: begin
            bothRun   = fwdS & revUse;
            runWanted = oneRun(fwdS, revUse);
            wantDir   = revUse;
            setIdx    = {selHiS, selLoS};
         end
         default: begin
            runWanted = runSw;
            wantDir   = dirSw;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Run state machine

   localparam [4:0] ST_STOP  = 5'b00001;
   localparam [4:0] ST_RUN   = 5'b00010;
   localparam [4:0] ST_DECEL = 5'b00100;
   localparam [4:0] ST_TURN  = 5'b01000;
   localparam [4:0] ST_ISTOP = 5'b10000;

   reg [4:0] next_state;

   always @* begin
      next_state = state;
      case (state)
         ST_STOP: begin
            if (runWanted && !lockout)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (!runWanted)
               next_state = ST_DECEL;
            else if (wantDir != dirCmd)
               next_state = ST_TURN;
         end
         ST_DECEL: begin
            if (runWanted && wantDir == dirCmd)
               next_state = ST_RUN;
            else if (stillS)
               next_state = ST_STOP;
         end
         ST_TURN: begin
            if (stillS)
               next_state = runWanted ? ST_RUN : ST_STOP;
         end
         ST_ISTOP: begin
            // Held until a single valid run input returns
            if (runWanted && !lockout)
               next_state = ST_RUN;
         end
         default: next_state = ST_STOP;
      endcase
      if (bothRun && extMode != `MRC_MODE_PANEL)
         next_state = ST_ISTOP;
   end

   ////////////////////////////////////////////////////////////////////
   // Power-on lockout, indication timer, outputs

   reg [1:0]  startCnt;
   reg        strapDone;
   reg [27:0] indTimer;
   reg [7:0]  tickAcc;

   wire extOnly  = (extMode == `MRC_MODE_EXT_ONLY);
   wire dialAct  = upEv | downEv | pressEv;
   wire viewBusy = (monView != `MRC_VIEW_IO);

   always @(posedge clk) begin
      if (srst) begin
         state       <= ST_STOP;
         prevPin     <= 5'h00;
         startCnt    <= 2'h0;
         strapDone   <= 1'b0;
         lockout     <= 1'b0;
         indTimer    <= 28'h0000000;
         tickAcc     <= 8'h00;
         instStopped <= 1'b0;
         runCmd      <= 1'b0;
         dirCmd      <= 1'b0;
         instantStop <= 1'b0;
         speedCmd    <= `MRC_SPEED_RST;
         accelCmd    <= `MRC_ACCEL_RST;
         decelCmd    <= `MRC_DECEL_RST;
         activeSet   <= 2'h0;
         power_on_run_lockout_code <= 8'h00;
         disabledInd <= 1'b0;
         pendingBlink <= 1'b0;
         rotPulse    <= 1'b0;
         fault_output <= 1'b0;
      end else begin
         prevPin <= {upS, downS, pressS, dirSw, tickS};
         // Strap caught only once synchroniser output is valid
         if (!strapDone) begin
            if (startCnt == `MRC_STARTUP_CYC) begin
               strapDone <= 1'b1;
               lockout   <= runSw;
            end else begin
               startCnt <= startCnt + 2'h1;
            end
         end else if (!runSw) begin
            lockout <= 1'b0;
         end
         state <= strapDone ? next_state : ST_STOP;
         instStopped <= (next_state == ST_ISTOP);
         runCmd      <= strapDone && (next_state == ST_RUN);
         instantStop <= (next_state == ST_ISTOP);
         if (strapDone && (next_state == ST_RUN || state == ST_STOP))
            dirCmd <= wantDir;
         // Live set follows selects, no stop on change
         activeSet <= setIdx;
         speedCmd  <= speedTab[setIdx];
         accelCmd  <= accelTab[setIdx];
         decelCmd  <= decelTab[setIdx];
         power_on_run_lockout_code <= lockout ? `MRC_LOCKOUT_CODE : 8'h00;
         fault_output <= ~(lockout | alarmS);
         pendingBlink <= (pendSpeed != speedTab[0]);
         // Disabled indication timer in external-only setting
         if (!extOnly)
            indTimer <= 28'h0000000;
         else if (dirEv || (dialAct && viewBusy))
            indTimer <= IND_HOLD_CYC;
         else if (indTimer != 28'h0000000)
            indTimer <= indTimer - 28'h0000001;
         disabledInd <= extOnly & (runSw | (indTimer != 28'h0000000));
         // Fractional divider: 30 pulses per shaft revolution
         rotPulse <= 1'b0;
         if (tickEv) begin
            if (tickAcc + `MRC_PULSES_PER_REV >= `MRC_TICKS_PER_REV) begin
               tickAcc  <= tickAcc + `MRC_PULSES_PER_REV - `MRC_TICKS_PER_REV;
               rotPulse <= 1'b1;
            end else begin
               tickAcc <= tickAcc + `MRC_PULSES_PER_REV;
            end
         end
      end
   end

endmodule

// File: sim/mrc_top_asserts.sv
/*
 Assertion checker for mrc_top, bound to every instance.
 Assumes the top module's port names and a synchronous active-high reset.
*/
module mrc_top_asserts #(
   parameter [27:0] IND_HOLD_CYC = 28'd50
) (
   input logic       clk,                         // Clock
   input logic       srst,                        // Reset
   input logic       forward_run_input,           // Forward pin
   input logic       counter_direction_run_input, // Reverse pin
   input logic       alarmIn,                     // Alarm pin
   input logic       runCmd,                      // Drive command
   input logic       instantStop,                 // Stop without ramp
   input logic [7:0] power_on_run_lockout_code,   // Alarm code
   input logic       rotPulse,                    // Pulse output
   input logic       fault_output                 // Fault output
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////
   sequence sBothRun;
      forward_run_input && counter_direction_run_input;
   endsequence
   sequence sNoRun;
      !forward_run_input && !counter_direction_run_input;
   endsequence
   AST_LOCKOUT_VALUE: assert property (
      power_on_run_lockout_code != 8'h00 |-> power_on_run_lockout_code == 8'h46 && !runCmd)
      else $error("lockout code wrong or drive on");
   AST_LOCKOUT_FAULT: assert property (
      (power_on_run_lockout_code == 8'h46) [*2] |-> !fault_output) else $error("fault high in lockout");
   AST_ALARM_FAULT: assert property (
      alarmIn [*4] |-> !fault_output) else $error("fault high during alarm");
   AST_FAULT_NORMAL: assert property (
      (!alarmIn && power_on_run_lockout_code == 8'h00) [*5] |-> fault_output)
      else $error("fault low without alarm");
   AST_ISTOP_NO_RUN: assert property (
      instantStop |-> !runCmd) else $error("drive on during instant stop");
   AST_ISTOP_CAUSE: assert property (
      $rose(instantStop) |-> $past(forward_run_input, 3) && $past(counter_direction_run_input, 3))
      else $error("instant stop without both inputs");
   AST_ISTOP_HOLD: assert property (
      sNoRun [*3] ##0 instantStop |=> instantStop) else $error("instant stop left with no input");
   AST_ISTOP_KEEP: assert property (
      sBothRun [*3] ##0 instantStop |=> instantStop) else $error("instant stop dropped");
   AST_PULSE_ONE: assert property (
      rotPulse |=> !rotPulse) else $error("pulse longer than a cycle");
endmodule

bind mrc_top mrc_top_asserts #(.IND_HOLD_CYC(IND_HOLD_CYC)) i_chk (
   .clk(clk), .srst(srst), .forward_run_input(forward_run_input),
   .counter_direction_run_input(counter_direction_run_input), .alarmIn(alarmIn), .runCmd(runCmd),
   .instantStop(instantStop), .power_on_run_lockout_code(power_on_run_lockout_code),
   .rotPulse(rotPulse), .fault_output(fault_output));

// File: sim/mrc_plc_model.sv
/*
 Programmable controller model driving the external run and select pins.
 Assumes the bench requests by level; pins change just after a clock edge.
*/
module mrc_plc_model (
   input  logic       clk,       // Clock
   input  logic       srst,      // Reset
   input  logic [1:0] req,       // 0 none, 1 fwd, 2 rev, 3 instant stop
   input  logic [1:0] setReq,    // Data set wanted
   input  logic       slow,      // Answer four cycles late
   input  logic       fourSpeed, // Only the forward run input exists
   output logic       fwdPin,    // Forward run
   output logic       revPin,    // Reverse run
   output logic       selLow,    // Select bit 0
   output logic       selHigh    // Select bit 1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pipe;
   logic [3:0]  cur;
   assign cur = slow ? pipe[15:12] : {setReq, req};
   always_ff @(posedge clk) begin
      if (srst) begin
         pipe <= 16'h0000;
         {selHigh, selLow, revPin, fwdPin} <= 4'h0;
      end else begin
         pipe <= {pipe[11:0], setReq, req};
         fwdPin <= cur[0];
         revPin <= cur[1] & ~fourSpeed;
         {selHigh, selLow} <= cur[3:2];
      end
   end
endmodule

// File: sim/motor_run_command_control_tb.sv
/*
 Self-checking bench for mrc_top with a controller model on the run pins.
 Assumes a 100 MHz clock and a shortened disabled-indication hold of 50.
*/
module motor_run_command_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [7:0]  haddr = 8'h00, lockCode;
   logic [1:0]  htrans = 2'h0, req = 2'h0, setReq = 2'h0, activeSet;
   logic [31:0] hwdata = 32'h0, hrdata, q, p;
   logic        runSwitch = 1'b1, dirSwitch = 1'b0, dialUp = 1'b0, dialDown = 1'b0, dialPress = 1'b0;
   logic        motorStill = 1'b1, motorTick = 1'b0, alarmIn = 1'b0, slow = 1'b0, fourSpeed = 1'b0;
   logic        fwdPin, revPin, selLow, selHigh, runCmd, dirCmd, instantStop;
   logic        disabledInd, pendingBlink, rotPulse, faultOut;
   logic [15:0] speedCmd, accelCmd, decelCmd;
   int          miscompares = 0, comparisons = 0, pulseCnt = 0, lowCnt = 0;
   int          tbl [3][4];
   logic [31:0] seed = 32'd99017;

   mrc_top #(.IND_HOLD_CYC(28'd50)) i_dut (
      .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .runSwitch(runSwitch), .dirSwitch(dirSwitch), .dialUp(dialUp), .dialDown(dialDown),
      .dialPress(dialPress), .forward_run_input(fwdPin), .counter_direction_run_input(revPin),
      .speed_select_low_bit(selLow), .speed_select_high_bit(selHigh), .motorStill(motorStill),
      .motorTick(motorTick), .alarmIn(alarmIn), .runCmd(runCmd), .dirCmd(dirCmd),
      .instantStop(instantStop), .speedCmd(speedCmd), .accelCmd(accelCmd), .decelCmd(decelCmd),
      .activeSet(activeSet), .power_on_run_lockout_code(lockCode), .disabledInd(disabledInd),
      .pendingBlink(pendingBlink), .rotPulse(rotPulse), .fault_output(faultOut));
   mrc_plc_model i_plc (
      .clk(clk), .srst(srst), .req(req), .setReq(setReq), .slow(slow), .fourSpeed(fourSpeed),
      .fwdPin(fwdPin), .revPin(revPin), .selLow(selLow), .selHigh(selHigh));

   ////////////////////////////////////////
   always #5 clk = ~clk;
   // Plant: shaft settles the cycle after drive drops
   always @(posedge clk) begin
      motorStill <= ~runCmd;
      if (rotPulse === 1'b1) pulseCnt++;
      if (runCmd === 1'b0) lowCnt++;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog sized well above the roughly 900 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim;
   end

   ////////////////////////////////////////
   initial begin
      settle(6);
      srst <= 1'b0;
      settle(10);
      chk(lockCode, 8'h46);
      chk(runCmd, 0);
      $display("lockout test done");
      for (int t = 0; t < 3; t++) begin
         for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            tbl[t][i] = seed[15:0];
            bus(8'h10 + 8'(16 * t + 4 * i), 1'b1, 32'(tbl[t][i]));
            bus(8'h10 + 8'(16 * t + 4 * i), 1'b0, 32'h0);
            chk(q, 32'(tbl[t][i]));
         end
      end
      bus(8'hC0, 1'b0, 32'h0);
      chk(q, 32'h0);
      bus(8'h00, 1'b1, 32'h3);
      bus(8'h00, 1'b0, 32'h0);
      chk(q[1:0], 2'h0);
      $display("register test done");
      runSwitch <= 1'b0;
      settle(12);
      runSwitch <= 1'b1;
      settle(12);
      chk(runCmd, 1);
      chk(speedCmd, tbl[0][0]);
      dialUp <= 1'b1;
      settle(6);
      dialUp <= 1'b0;
      settle(6);
      dialDown <= 1'b1;
      settle(12);
      chk(pendingBlink, 1);
      bus(8'h08, 1'b0, 32'h0);
      p = 32'h1;
      chk(q, p);
      dialPress <= 1'b1;
      settle(6);
      dialPress <= 1'b0;
      settle(6);
      chk(pendingBlink, 0);
      bus(8'h10, 1'b0, 32'h0);
      chk(q, p);
      chk(speedCmd, p[15:0]);
      tbl[0][0] = p[15:0];
      $display("panel test done");
      bus(8'h00, 1'b1, 32'h31);
      slow <= 1'b1;
      fourSpeed <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         setReq <= 2'(i);
         req <= 2'h1;
         settle(12);
         if (i == 0) lowCnt = 0;
         chk(activeSet, i);
         chk({speedCmd, accelCmd}, {16'(tbl[0][i]), 16'(tbl[1][i])});
         chk(decelCmd, tbl[2][i]);
      end
      chk(lowCnt, 0);
      slow <= 1'b0;
      fourSpeed <= 1'b0;
      req <= 2'h2;
      settle(12);
      chk(runCmd, 0);
      $display("speed select test done");
      bus(8'h00, 1'b1, 32'h01);
      setReq <= 2'h0;
      req <= 2'h1;
      settle(12);
      chk({runCmd, dirCmd}, 2'b10);
      runSwitch <= 1'b0;
      settle(12);
      chk(runCmd, 0);
      runSwitch <= 1'b1;
      settle(12);
      lowCnt = 0;
      dirSwitch <= 1'b1;
      settle(20);
      chk(lowCnt > 0, 1);
      chk({runCmd, dirCmd}, 2'b11);
      req <= 2'h3;
      settle(12);
      chk({instantStop, runCmd}, 2'b10);
      req <= 2'h0;
      settle(12);
      chk(instantStop, 1);
      req <= 2'h1;
      settle(12);
      chk({instantStop, runCmd}, 2'b01);
      req <= 2'h0;
      settle(12);
      chk({instantStop, runCmd}, 2'b00);
      dirSwitch <= 1'b0;
      $display("external panel test done");
      bus(8'h00, 1'b1, 32'h02);
      dirSwitch <= 1'b1;
      req <= 2'h1;
      settle(12);
      chk({runCmd, dirCmd}, 2'b10);
      chk(disabledInd, 1);
      runSwitch <= 1'b0;
      settle(70);
      chk({disabledInd, runCmd}, 2'b01);
      dialDown <= 1'b0;
      settle(12);
      chk({disabledInd, pendingBlink}, 2'b10);
      settle(30);
      chk(disabledInd, 1);
      settle(20);
      chk(disabledInd, 0);
      bus(8'h00, 1'b1, 32'h0E);
      dialDown <= 1'b1;
      settle(12);
      chk(disabledInd, 0);
      req <= 2'h2;
      settle(20);
      chk({runCmd, dirCmd}, 2'b11);
      req <= 2'h0;
      $display("external only test done");
      pulseCnt = 0;
      repeat (60) begin
         motorTick <= 1'b1;
         settle(3);
         motorTick <= 1'b0;
         settle(3);
      end
      settle(6);
      chk(pulseCnt, 30);
      chk(faultOut, 1);
      alarmIn <= 1'b1;
      settle(8);
      chk(faultOut, 0);
      $display("pulse and alarm test done");
      end_sim;
   end
endmodule
